// ===== design/calc_pkg.sv
// Constants and types shared by the instruction execution block
package calc_pkg;
  localparam logic [7:0]  CODE_CALC       = 8'h2D;
  localparam logic [7:0]  CODE_RESTART    = 8'h30;
  localparam logic [7:0]  CODE_DEC_BRANCH = 8'h31;
  localparam logic [7:0]  TYPE_ADD        = 8'h00;
  localparam logic [7:0]  TYPE_SUB        = 8'h01;
  localparam logic [7:0]  TYPE_MUL        = 8'h02;
  localparam logic [7:0]  TYPE_DIV        = 8'h03;
  localparam logic [7:0]  TYPE_MOD        = 8'h04;
  localparam logic [7:0]  TYPE_AND        = 8'h05;
  localparam logic [7:0]  TYPE_OR         = 8'h06;
  localparam logic [7:0]  TYPE_XOR        = 8'h07;
  localparam logic [7:0]  TYPE_NOT        = 8'h08;
  localparam logic [7:0]  TYPE_LOAD       = 8'h09;
  localparam logic [7:0]  TYPE_COMP       = 8'h0B;
  localparam logic [7:0]  STATUS_OK       = 8'h64;
  localparam logic [7:0]  STATUS_ERR_TYPE = 8'h03;
  localparam logic [7:0]  STATUS_ERR_DIV  = 8'h04;
  localparam logic [7:0]  VAR_LAST        = 8'hFF;
  localparam logic [3:0]  STACK_MAX       = 4'h8;
  localparam logic [31:0] ONE             = 32'h0000_0001;
  localparam int          FLAG_ZERO       = 0;
  localparam int          FLAG_EQ         = 1;
  localparam int          FLAG_GT         = 2;
  localparam int          FLAG_LT         = 3;
  localparam logic [3:0]  FLAGS_RESET     = 4'h0;
  typedef enum logic [1:0] {
    S_CLEAR = 2'b00,
    S_IDLE  = 2'b01,
    S_EXEC  = 2'b10
  } state_t;
endpackage : calc_pkg

// ===== design/calc_if.sv
// Operand and result bundle between the executor and its arithmetic unit
`timescale 1ns/1ps
interface calc_if;
  logic [7:0]  op;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] result;
  logic        write;
  logic        invalid;
  logic        div_err;
  logic        eq;
  logic        gt;
  logic        lt;
  modport exec (output op, a, b, input result, write, invalid, div_err, eq, gt, lt);
  modport alu  (input op, a, b, output result, write, invalid, div_err, eq, gt, lt);
endinterface : calc_if

// ===== design/var_alu.sv
// Signed arithmetic and logic unit for user variable calculations
`timescale 1ns/1ps
module var_alu
  import calc_pkg::*;
(
  calc_if.alu port
);
  always_comb begin
    port.result  = port.a;
    port.write   = 1'b1;
    port.invalid = 1'b0;
    port.div_err = 1'b0;
    port.eq      = (port.a == port.b);
    port.gt      = ($signed(port.a) > $signed(port.b));
    port.lt      = ($signed(port.a) < $signed(port.b));
    case (port.op)
      TYPE_ADD: port.result = port.a + port.b;
      TYPE_SUB: port.result = port.a - port.b;
      TYPE_MUL: port.result = 32'($signed(port.a) * $signed(port.b));
      TYPE_DIV, TYPE_MOD: begin
        // Divide by zero would leave the variable undefined, so it is refused
        if (port.b == 32'h0000_0000) begin
          port.div_err = 1'b1;
          port.write   = 1'b0;
        end else if (port.op == TYPE_DIV) begin
          port.result = $signed(port.a) / $signed(port.b);
        end else begin
          port.result = $signed(port.a) % $signed(port.b);
        end
      end
      TYPE_AND:  port.result = port.a & port.b;
      TYPE_OR:   port.result = port.a | port.b;
      TYPE_XOR:  port.result = port.a ^ port.b;
      TYPE_NOT:  port.result = ~port.a;
      TYPE_LOAD: port.result = port.b;
      TYPE_COMP: port.write  = 1'b0;
      default: begin
        port.write   = 1'b0;
        port.invalid = 1'b1;
      end
    endcase
  end
endmodule : var_alu

// ===== design/user_var_calc_restart_loop.sv
// Executor for variable-immediate calculation, restart and decrement-branch
// Operation
// - Code 45 is var_immediate_calc; variable index from bank byte, operand from value.
// - Types 0-4 add, subtract, multiply, divide, modulo operand into variable.
// - Types 5-7 AND, OR, XOR with operand; type 8 inverts variable only.
// - Type 9 loads operand; type 11 compares without changing the variable.
// - A direct-mode calculation answers status 100 on success.
// - Code 48 is restart; value is the restart address, other fields ignored.
// - Restart stops program, empties the subroutine stack, clears the flags, jumps to address.
// - Restart is accepted anywhere, even nested; pending return addresses are dropped.
// - Code 49 is decrement_branch_nonzero; index from type byte, target from value.
// - Decrement and store; jump if the new value is non-zero, else step on.
// - Compare or assignment outcome is kept as condition flags for later tests.
// - Subroutine stack holds at most eight return addresses; restart empties it.
`timescale 1ns/1ps
module user_var_calc_restart_loop
  import calc_pkg::*;
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  // Instruction in
  input  wire logic        INSTR_VALID,
  input  wire logic [7:0]  INSTR_CODE,
  input  wire logic [7:0]  INSTR_TYPE,
  input  wire logic [7:0]  INSTR_BANK,
  input  wire logic [31:0] INSTR_VALUE,
  input  wire logic        INSTR_DIRECT,
  output logic             INSTR_READY,
  // Completion and reply
  output logic             DONE,
  output logic             REPLY_VALID,
  output logic [7:0]       REPLY_STATUS,
  output logic [31:0]      REPLY_VALUE,
  // Program flow
  output logic             PC_LOAD,
  output logic             PC_STEP,
  output logic [31:0]      PC_TARGET,
  output logic             PROG_RESTART,
  output logic [3:0]       FLAGS,
  // Subroutine stack
  input  wire logic        STACK_PUSH,
  input  wire logic [31:0] STACK_PUSH_ADDR,
  input  wire logic        STACK_POP,
  output logic [3:0]       STACK_DEPTH,
  output logic [31:0]      STACK_TOP,
  // Variable readback
  input  wire logic [7:0]  VAR_RD_INDEX,
  output logic [31:0]      VAR_RD_DATA
);
  import calc_pkg::*;

  calc_if alu_bus ();
  var_alu u_alu (.port(alu_bus));

  logic [31:0] var_mem [0:255];
  logic [31:0] stack_mem [0:7];
  state_t      state, next_state;
  logic [7:0]  clr_idx, next_clr_idx;
  logic [7:0]  code_q, type_q, bank_q, next_code, next_type, next_bank;
  logic [31:0] value_q, next_value;
  logic        direct_q, next_direct;
  logic        next_ready, next_done, next_reply_valid, next_pc_load, next_pc_step, next_restart;
  logic [7:0]  next_status;
  logic [31:0] next_reply_value, next_pc_target;
  logic [3:0]  next_flags, next_depth;
  logic        wr_en;
  logic [7:0]  wr_idx, var_idx;
  logic [31:0] wr_data, cur_var;
  logic        push_ok, pop_ok;

  // Calculation takes its index from the bank byte, the loop counter from type
  assign var_idx = (code_q == CODE_DEC_BRANCH) ? type_q : bank_q;
  assign cur_var = var_mem[var_idx];
  // Decrement-branch reuses the subtractor with a constant one
  assign alu_bus.op = (code_q == CODE_DEC_BRANCH) ? TYPE_SUB : type_q;
  assign alu_bus.a  = cur_var;
  assign alu_bus.b  = (code_q == CODE_DEC_BRANCH) ? ONE : value_q;
  assign push_ok    = STACK_PUSH && (STACK_DEPTH < STACK_MAX);
  assign pop_ok     = STACK_POP && (STACK_DEPTH != 4'h0);

  always_comb begin
    next_state       = state;
    next_clr_idx     = clr_idx;
    next_code        = code_q;
    next_type        = type_q;
    next_bank        = bank_q;
    next_value       = value_q;
    next_direct      = direct_q;
    next_done        = 1'b0;
    next_reply_valid = 1'b0;
    next_status      = REPLY_STATUS;
    next_reply_value = REPLY_VALUE;
    next_pc_load     = 1'b0;
    next_pc_step     = 1'b0;
    next_pc_target   = PC_TARGET;
    next_restart     = 1'b0;
    next_flags       = FLAGS;
    next_depth       = STACK_DEPTH;
    wr_en            = 1'b0;
    wr_idx           = var_idx;
    wr_data          = alu_bus.result;
    if (push_ok) begin
      next_depth = STACK_DEPTH + 4'h1;
    end else if (pop_ok) begin
      next_depth = STACK_DEPTH - 4'h1;
    end
    case (state)
      S_CLEAR: begin
        // Zero every variable once after reset so no word reads undefined
        wr_en        = 1'b1;
        wr_idx       = clr_idx;
        wr_data      = 32'h0000_0000;
        next_clr_idx = clr_idx + 8'h01;
        if (clr_idx == VAR_LAST) begin
          next_state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (INSTR_VALID) begin
          next_code   = INSTR_CODE;
          next_type   = INSTR_TYPE;
          next_bank   = INSTR_BANK;
          next_value  = INSTR_VALUE;
          next_direct = INSTR_DIRECT;
          next_state  = S_EXEC;
        end
      end
      S_EXEC: begin
        next_done  = 1'b1;
        next_state = S_IDLE;
        if (code_q == CODE_CALC) begin
          next_reply_valid = direct_q;
          next_reply_value = value_q;
          next_pc_step     = 1'b1;
          if (alu_bus.invalid) begin
            next_status = STATUS_ERR_TYPE;
          end else if (alu_bus.div_err) begin
            next_status = STATUS_ERR_DIV;
          end else begin
            next_status = STATUS_OK;
            wr_en       = alu_bus.write;
            if (type_q == TYPE_COMP) begin
              next_flags[FLAG_ZERO] = alu_bus.eq;
              next_flags[FLAG_EQ]   = alu_bus.eq;
              next_flags[FLAG_GT]   = alu_bus.gt;
              next_flags[FLAG_LT]   = alu_bus.lt;
            end else begin
              next_flags            = FLAGS_RESET;
              next_flags[FLAG_ZERO] = (alu_bus.result == 32'h0000_0000);
            end
          end
        end else if (code_q == CODE_RESTART) begin
          // Restart wins over any stack push or pop in the same cycle
          next_restart   = 1'b1;
          next_depth     = 4'h0;
          next_flags     = FLAGS_RESET;
          next_pc_load   = 1'b1;
          next_pc_target = value_q;
        end else if (code_q == CODE_DEC_BRANCH) begin
          wr_en = 1'b1;
          // Non-zero, not greater than zero: a negative count keeps looping
          if (alu_bus.result != 32'h0000_0000) begin
            next_pc_load   = 1'b1;
            next_pc_target = value_q;
          end else begin
            next_pc_step = 1'b1;
          end
        end
      end
      default: next_state = S_IDLE;
    endcase
    next_ready = (next_state == S_IDLE);
  end

  always_ff @(posedge REF_CLK) begin
    if (wr_en) begin
      var_mem[wr_idx] <= wr_data;
    end
    if (push_ok) begin
      stack_mem[STACK_DEPTH[2:0]] <= STACK_PUSH_ADDR;
    end
    VAR_RD_DATA <= var_mem[VAR_RD_INDEX];
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      state        <= S_CLEAR;
      clr_idx      <= 8'h00;
      code_q       <= 8'h00;
      type_q       <= 8'h00;
      bank_q       <= 8'h00;
      value_q      <= 32'h0000_0000;
      direct_q     <= 1'b0;
      INSTR_READY  <= 1'b0;
      DONE         <= 1'b0;
      REPLY_VALID  <= 1'b0;
      REPLY_STATUS <= 8'h00;
      REPLY_VALUE  <= 32'h0000_0000;
      PC_LOAD      <= 1'b0;
      PC_STEP      <= 1'b0;
      PC_TARGET    <= 32'h0000_0000;
      PROG_RESTART <= 1'b0;
      FLAGS        <= FLAGS_RESET;
      STACK_DEPTH  <= 4'h0;
    end else begin
      state        <= next_state;
      clr_idx      <= next_clr_idx;
      code_q       <= next_code;
      type_q       <= next_type;
      bank_q       <= next_bank;
      value_q      <= next_value;
      direct_q     <= next_direct;
      INSTR_READY  <= next_ready;
      DONE         <= next_done;
      REPLY_VALID  <= next_reply_valid;
      REPLY_STATUS <= next_status;
      REPLY_VALUE  <= next_reply_value;
      PC_LOAD      <= next_pc_load;
      PC_STEP      <= next_pc_step;
      PC_TARGET    <= next_pc_target;
      PROG_RESTART <= next_restart;
      FLAGS        <= next_flags;
      STACK_DEPTH  <= next_depth;
    end
  end

  // Top entry registered so the output stays a flop; it lags a push by a cycle
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      STACK_TOP <= 32'h0000_0000;
    end else if (STACK_DEPTH != 4'h0) begin
      STACK_TOP <= stack_mem[3'(STACK_DEPTH - 4'h1)];
    end else begin
      STACK_TOP <= 32'h0000_0000;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  AST_CALC_ADD: assert property (
    (state == S_EXEC && code_q == CODE_CALC && type_q == TYPE_ADD)
      |=> var_mem[$past(var_idx)] == $past(cur_var) + $past(value_q))
    else $error("add result not stored in variable");
  AST_CALC_NOT: assert property (
    (state == S_EXEC && code_q == CODE_CALC && type_q == TYPE_NOT)
      |=> var_mem[$past(bank_q)] == ~$past(cur_var))
    else $error("invert did not store the inverted variable");
  AST_COMP_KEEPS: assert property (
    (state == S_EXEC && code_q == CODE_CALC && type_q == TYPE_COMP)
      |=> var_mem[$past(bank_q)] == $past(cur_var) && FLAGS[FLAG_EQ] == $past(cur_var == value_q))
    else $error("compare changed variable or equal flag wrong");
  AST_BAD_TYPE: assert property (
    (state == S_EXEC && code_q == CODE_CALC && (type_q == 8'h0A || type_q > TYPE_COMP) && direct_q)
      |=> REPLY_VALID && REPLY_STATUS == STATUS_ERR_TYPE && var_mem[$past(bank_q)] == $past(cur_var))
    else $error("invalid type not refused");
  AST_OK_REPLY: assert property (
    (state == S_EXEC && code_q == CODE_CALC && type_q <= TYPE_LOAD && type_q != TYPE_DIV
      && type_q != TYPE_MOD && direct_q) |=> REPLY_VALID && REPLY_STATUS == STATUS_OK && DONE)
    else $error("successful calculation did not answer status 100");
  AST_RESTART: assert property (
    (state == S_EXEC && code_q == CODE_RESTART)
      |=> PROG_RESTART && PC_LOAD && PC_TARGET == $past(value_q) && STACK_DEPTH == 4'h0 && FLAGS == 4'h0)
    else $error("restart did not clear state and jump");
  AST_LOOP_TAKEN: assert property (
    (state == S_EXEC && code_q == CODE_DEC_BRANCH && cur_var != ONE)
      |=> PC_LOAD && !PC_STEP && PC_TARGET == $past(value_q) && var_mem[$past(type_q)] == $past(cur_var) - ONE)
    else $error("decrement-branch did not jump on non-zero");
  AST_LOOP_DONE: assert property (
    (state == S_EXEC && code_q == CODE_DEC_BRANCH && cur_var == ONE)
      |=> PC_STEP && !PC_LOAD && INSTR_READY && DONE && var_mem[$past(type_q)] == 32'h0000_0000)
    else $error("decrement-branch jumped on zero");
  AST_STACK_LIMIT: assert property (
    (STACK_DEPTH == STACK_MAX && STACK_PUSH && !STACK_POP && !(state == S_EXEC && code_q == CODE_RESTART))
      |=> STACK_DEPTH == STACK_MAX)
    else $error("push accepted on full stack");
endmodule : user_var_calc_restart_loop

// ===== sim/instr_host.sv
// Issuer model: host link or stored program offering one instruction at a time
`timescale 1ns/1ps
module instr_host
  import calc_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Instruction out
  output logic             valid,
  output logic [7:0]       code,
  output logic [7:0]       kind,
  output logic [7:0]       bank,
  output logic [31:0]      value,
  output logic             direct,
  input  wire logic        ready,
  // Completion in
  input  wire logic        done,
  input  wire logic        reply_valid,
  input  wire logic        pc_load,
  input  wire logic        pc_step,
  input  wire logic        restart
);
  logic [3:0] seen;
  logic       ok;
  int         waits;

  initial begin
    valid = 1'b0;
    code = 8'h00;
    kind = 8'h00;
    bank = 8'h00;
    value = 32'h0000_0000;
    direct = 1'b0;
  end

  task automatic issue(input logic [7:0] c, input logic [7:0] t, input logic [7:0] b,
                       input logic [31:0] v, input logic d);
    @(negedge clk);
    code = c;
    kind = t;
    bank = b;
    value = v;
    // Loop and restart only ever come from a stored program
    direct = (c == CODE_RESTART || c == CODE_DEC_BRANCH) ? 1'b0 : d;
    valid = 1'b1;
    waits = 0;
    while (ready !== 1'b1 && waits < 400) begin
      @(negedge clk);
      waits++;
    end
    @(negedge clk);
    valid = 1'b0;
    // Fields no longer qualified: show a changed pattern, not the last one
    value = ~v;
    kind = ~t;
    bank = ~b;
    for (int i = 0; i < 6 && done !== 1'b1; i++) @(negedge clk);
    seen = {restart, pc_step, pc_load, reply_valid};
    ok = (done === 1'b1);
  endtask : issue
endmodule : instr_host

// ===== sim/user_var_calc_restart_loop_test.sv
// Self-checking bench for the calculation, restart and loop executor
`timescale 1ns/1ps
module user_var_calc_restart_loop_test;
  import calc_pkg::*;
  logic        REF_CLK, RESET, INSTR_VALID, INSTR_DIRECT, INSTR_READY, DONE, REPLY_VALID;
  logic [7:0]  INSTR_CODE, INSTR_TYPE, INSTR_BANK, REPLY_STATUS, VAR_RD_INDEX;
  logic [31:0] INSTR_VALUE, REPLY_VALUE, PC_TARGET, STACK_PUSH_ADDR, STACK_TOP, VAR_RD_DATA;
  logic        PC_LOAD, PC_STEP, PROG_RESTART, STACK_PUSH, STACK_POP;
  logic [3:0]  FLAGS, STACK_DEPTH;
  logic [31:0] rd;
  int          mismatches, n_compared, cycles;

  user_var_calc_restart_loop DUT (.REF_CLK(REF_CLK), .RESET(RESET), .INSTR_VALID(INSTR_VALID),
    .INSTR_CODE(INSTR_CODE), .INSTR_TYPE(INSTR_TYPE), .INSTR_BANK(INSTR_BANK),
    .INSTR_VALUE(INSTR_VALUE), .INSTR_DIRECT(INSTR_DIRECT), .INSTR_READY(INSTR_READY), .DONE(DONE),
    .REPLY_VALID(REPLY_VALID), .REPLY_STATUS(REPLY_STATUS), .REPLY_VALUE(REPLY_VALUE),
    .PC_LOAD(PC_LOAD), .PC_STEP(PC_STEP), .PC_TARGET(PC_TARGET), .PROG_RESTART(PROG_RESTART),
    .FLAGS(FLAGS), .STACK_PUSH(STACK_PUSH), .STACK_PUSH_ADDR(STACK_PUSH_ADDR), .STACK_POP(STACK_POP),
    .STACK_DEPTH(STACK_DEPTH), .STACK_TOP(STACK_TOP), .VAR_RD_INDEX(VAR_RD_INDEX),
    .VAR_RD_DATA(VAR_RD_DATA));

  instr_host HOST (.clk(REF_CLK), .valid(INSTR_VALID), .code(INSTR_CODE), .kind(INSTR_TYPE),
    .bank(INSTR_BANK), .value(INSTR_VALUE), .direct(INSTR_DIRECT), .ready(INSTR_READY), .done(DONE),
    .reply_valid(REPLY_VALID), .pc_load(PC_LOAD), .pc_step(PC_STEP), .restart(PROG_RESTART));

  initial REF_CLK = 1'b0;
  always #5 REF_CLK = ~REF_CLK;

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic read_var(input logic [7:0] idx);
    @(negedge REF_CLK);
    VAR_RD_INDEX = idx;
    @(negedge REF_CLK);
    rd = VAR_RD_DATA;
  endtask : read_var

  task automatic test_calc_ops();
    logic [7:0]  types [10] = '{TYPE_LOAD, TYPE_ADD, TYPE_SUB, TYPE_MUL, TYPE_DIV, TYPE_MOD,
                                TYPE_OR, TYPE_AND, TYPE_XOR, TYPE_NOT};
    logic [31:0] ops [10] = '{32'h0000_0064, 32'h0000_0017, 32'h0000_0003, 32'h0000_0003,
                              32'h0000_0007, 32'h0000_000A, 32'h0000_00F0, 32'h0000_003C,
                              32'h0000_000F, 32'h0000_1234};
    logic [31:0] res [10] = '{32'h0000_0064, 32'h0000_007B, 32'h0000_0078, 32'h0000_0168,
                              32'h0000_0033, 32'h0000_0001, 32'h0000_00F1, 32'h0000_0030,
                              32'h0000_003F, 32'hFFFF_FFC0};
    for (int i = 0; i < 10; i++) begin
      HOST.issue(CODE_CALC, types[i], VAR_LAST, ops[i], 1'b1);
      check("done_pulse", 32'h0000_0001, {31'h0, HOST.ok});
      check("ready_again", 32'h0000_0001, {31'h0, INSTR_READY});
      check("reply_pulse", 32'h0000_0001, {31'h0, HOST.seen[0]});
      check("status", {24'h0, STATUS_OK}, {24'h0, REPLY_STATUS});
      check("reply_value", ops[i], REPLY_VALUE);
      read_var(VAR_LAST);
      check("variable", res[i], rd);
    end
  endtask : test_calc_ops

  task automatic test_compare_invalid();
    logic [7:0] types [3] = '{8'h0A, 8'h0C, TYPE_DIV};
    logic [7:0] stat [3] = '{STATUS_ERR_TYPE, STATUS_ERR_TYPE, STATUS_ERR_DIV};
    HOST.issue(CODE_CALC, TYPE_COMP, VAR_LAST, 32'hFFFF_FFC0, 1'b1);
    check("flags_equal", 32'h0000_0003, {28'h0, FLAGS});
    HOST.issue(CODE_CALC, TYPE_COMP, VAR_LAST, 32'h0000_0000, 1'b1);
    check("flags_lower", 32'h0000_0008, {28'h0, FLAGS});
    for (int i = 0; i < 3; i++) begin
      HOST.issue(CODE_CALC, types[i], VAR_LAST, 32'h0000_0000, 1'b1);
      check("error_status", {24'h0, stat[i]}, {24'h0, REPLY_STATUS});
      check("flags_kept", 32'h0000_0008, {28'h0, FLAGS});
    end
    read_var(VAR_LAST);
    check("variable_kept", 32'hFFFF_FFC0, rd);
  endtask : test_compare_invalid

  task automatic test_restart();
    for (int i = 0; i < 9; i++) begin
      @(negedge REF_CLK);
      STACK_PUSH = 1'b1;
      STACK_PUSH_ADDR = 32'h0000_0010 * i;
    end
    @(negedge REF_CLK);
    STACK_PUSH = 1'b0;
    @(negedge REF_CLK);
    check("depth_full", 32'h0000_0008, {28'h0, STACK_DEPTH});
    check("top", 32'h0000_0070, STACK_TOP);
    STACK_POP = 1'b1;
    @(negedge REF_CLK);
    STACK_POP = 1'b0;
    check("depth_pop", 32'h0000_0007, {28'h0, STACK_DEPTH});
    // Nested seven deep in the stack, with flags still set
    HOST.issue(CODE_RESTART, 8'h07, 8'h03, 32'h0000_000A, 1'b0);
    check("restart_pulses", 32'h0000_000A, {28'h0, HOST.seen});
    check("restart_target", 32'h0000_000A, PC_TARGET);
    check("depth_cleared", 32'h0000_0000, {28'h0, STACK_DEPTH});
    check("flags_cleared", 32'h0000_0000, {28'h0, FLAGS});
  endtask : test_restart

  task automatic test_loop();
    logic [31:0] res [3] = '{32'h0000_0001, 32'h0000_0000, 32'hFFFF_FFFF};
    logic [3:0]  pcs [3] = '{4'h2, 4'h4, 4'h2};
    HOST.issue(CODE_CALC, TYPE_LOAD, 8'h2A, 32'h0000_0002, 1'b0);
    check("no_reply", 32'h0000_0000, {31'h0, HOST.seen[0]});
    for (int i = 0; i < 3; i++) begin
      HOST.issue(CODE_DEC_BRANCH, 8'h2A, 8'h5A, 32'h0000_0001, 1'b0);
      check("loop_pc", {28'h0, pcs[i]}, {28'h0, HOST.seen});
      check("loop_target", 32'h0000_0001, PC_TARGET);
      read_var(8'h2A);
      check("loop_variable", res[i], rd);
    end
  endtask : test_loop

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      summarize();
    end
  end

  initial begin
    RESET = 1'b1;
    STACK_PUSH = 1'b0;
    STACK_POP = 1'b0;
    STACK_PUSH_ADDR = 32'h0000_0000;
    VAR_RD_INDEX = 8'h00;
    // Count rising edges so the first clock transition from unknown is not taken as one
    repeat (2) @(posedge REF_CLK);
    @(negedge REF_CLK);
    RESET = 1'b0;
    test_calc_ops();
    test_compare_invalid();
    test_restart();
    test_loop();
    summarize();
  end
endmodule : user_var_calc_restart_loop_test
